// ### rtl/mls_defines.svh
// Purpose: Constants for the line signalling block
// Assumes: clk_sys at 250 MHz
// Notes: Times in ns, counts derived from the system clock period
`ifndef MLS_DEFINES_SVH
`define MLS_DEFINES_SVH
`define MLS_CLK_PERIOD_NS 4
`define MLS_HOLD_TIME_NS 4000
`define MLS_SHORT_PULSE_NS 4000
`define MLS_LONG_PULSE_NS 8000
`define MLS_HOLD_CYCLES (`MLS_HOLD_TIME_NS / `MLS_CLK_PERIOD_NS)
`define MLS_SHORT_CYCLES (`MLS_SHORT_PULSE_NS / `MLS_CLK_PERIOD_NS)
`define MLS_LONG_CYCLES (`MLS_LONG_PULSE_NS / `MLS_CLK_PERIOD_NS)
`define MLS_REF_DIV_DEFAULT 32
`define MLS_CNT_W 12
`endif

// ### rtl/mls_line_signalling.sv
// Purpose: Line signalling between data-link logic and a medium attachment unit
// Assumes: All inputs synchronous to clk_sys; chip_reset_low already synchronous
// Notes: Timing counts in ticks of the divided tick, default one tick per cycle
`timescale 1ns/1ps
`include "mls_defines.svh"
module mls_line_signalling import mls_pkg::*; #(
   parameter int CNT_W = `MLS_CNT_W,
   parameter int SHORT_TICKS = `MLS_SHORT_CYCLES,
   parameter int LONG_TICKS = `MLS_LONG_CYCLES,
   parameter int HOLD_TICKS = `MLS_HOLD_CYCLES
) (
   input wire logic clk_sys,
   input wire logic rst,
   input wire logic chip_reset_low,
   input wire logic [7:0] tick_div,
   input wire logic tx_mode_add,
   input wire logic tx_active_in,
   input wire logic tx_bit_in,
   input wire logic carrier_detect_in,
   input wire logic receive_symbol_in,
   input wire logic [7:0] irq_sources,
   output logic line_drive_gate,
   output logic transmit_symbol_out,
   output logic transmit_activity_flag,
   output logic transition_pulse_low,
   output logic rx_valid,
   output logic rx_bit,
   output logic irq_out_low
);
   mls_state_t state;
   logic [7:0] div_count;
   logic tick;
   logic prev_active;
   logic pulse_busy;

   wire any_reset = rst || !chip_reset_low;
   wire div_wrap = (div_count >= tick_div);
   wire next_tick = div_wrap;
   wire [7:0] next_div_count = div_wrap ? 8'h00 : div_count + 8'h01;

   // Tx encoding
   wire mode_add = (mls_mode_t'(tx_mode_add) == mls_mode_add);
   // Add mode shows unequal lines when idle; enable-low idles on a high gate
   wire gate_when_active = mode_add ? tx_bit_in : 1'b0;
   wire symbol_when_idle = mode_add ? 1'b0 : transmit_symbol_out;
   wire next_gate = tx_active_in ? gate_when_active : 1'b1;
   wire next_symbol = tx_active_in ? tx_bit_in : symbol_when_idle;

   wire frame_start = tx_active_in && !prev_active;
   wire frame_end = !tx_active_in && prev_active;
   wire symbol_change = tx_active_in && prev_active && (next_symbol != transmit_symbol_out);
   wire pulse_short = frame_start || frame_end;
   wire pulse_fire = pulse_short || symbol_change;
   wire [CNT_W-1:0] pulse_load = pulse_short ? CNT_W'(SHORT_TICKS) : CNT_W'(LONG_TICKS);
   wire pulse_done;
   wire hold_done;

   mls_timer #(.W(CNT_W)) u_pulse_timer (
      .clk_sys(clk_sys),
      .rst(any_reset),
      .tick(tick),
      .load(pulse_fire),
      .load_value(pulse_load),
      .done(pulse_done)
   );

   mls_timer #(.W(CNT_W)) u_hold_timer (
      .clk_sys(clk_sys),
      .rst(any_reset),
      .tick(tick),
      .load(frame_end),
      .load_value(CNT_W'(HOLD_TICKS)),
      .done(hold_done)
   );

   mls_state_t next_state;

   // Hold restarts cleanly when a new frame begins before the flag drops.
   // On the load edge hold_done still shows the old zero count, hence the guard.
   always_comb begin
      next_state = state;
      case (state)
         mls_idle: begin
            if (tx_active_in) begin
               next_state = mls_active;
            end
         end
         mls_active: begin
            if (!tx_active_in) begin
               next_state = mls_hold;
            end
         end
         mls_hold: begin
            if (tx_active_in) begin
               next_state = mls_active;
            end else if (hold_done && !frame_end) begin
               next_state = mls_idle;
            end
         end
         default: begin
            next_state = mls_idle;
         end
      endcase
   end

   // Pulse low while a fired pulse counts down; a new edge restarts it
   wire next_pulse_busy = pulse_fire || (pulse_busy && !pulse_done);
   wire next_activity = (next_state != mls_idle);
   wire next_rx_valid = carrier_detect_in;
   wire next_rx_bit = carrier_detect_in & receive_symbol_in;
   wire next_irq_low = ~(|irq_sources);


   // Divider: timers count ticks, so slower reference rates only change tick_div
   always_ff @(posedge clk_sys) begin
      if (any_reset) begin
         div_count <= 8'h00;
         tick <= 1'b0;
      end else begin
         div_count <= next_div_count;
         tick <= next_tick;
      end
   end

   // Frame tracking
   always_ff @(posedge clk_sys) begin
      if (any_reset) begin
         state <= mls_idle;
         prev_active <= 1'b0;
      end else begin
         state <= next_state;
         prev_active <= tx_active_in;
      end
   end

   // Transition pulse; output is the inverse of the next busy state
   always_ff @(posedge clk_sys) begin
      if (any_reset) begin
         pulse_busy <= 1'b0;
         transition_pulse_low <= 1'b1;
      end else begin
         pulse_busy <= next_pulse_busy;
         transition_pulse_low <= ~next_pulse_busy;
      end
   end

   // Transmit lines
   always_ff @(posedge clk_sys) begin
      if (any_reset) begin
         line_drive_gate <= 1'b1;
         transmit_symbol_out <= 1'b0;
      end else begin
         line_drive_gate <= next_gate;
         transmit_symbol_out <= next_symbol;
      end
   end

   // Activity flag covers the frame and the hold time
   always_ff @(posedge clk_sys) begin
      if (any_reset) begin
         transmit_activity_flag <= 1'b0;
      end else begin
         transmit_activity_flag <= next_activity;
      end
   end

   // Receive side: no filtering, the line unit owns noise rejection
   always_ff @(posedge clk_sys) begin
      if (any_reset) begin
         rx_valid <= 1'b0;
         rx_bit <= 1'b0;
      end else begin
         rx_valid <= next_rx_valid;
         rx_bit <= next_rx_bit;
      end
   end

   // Interrupt level, low while any source stands
   always_ff @(posedge clk_sys) begin
      if (any_reset) begin
         irq_out_low <= 1'b1;
      end else begin
         irq_out_low <= next_irq_low;
      end
   end
endmodule : mls_line_signalling

// ### rtl/mls_pkg.sv
// Purpose: Types for the line signalling block
// Assumes: Nothing
// Notes: Constants live in mls_defines.svh
package mls_pkg;
   typedef enum logic [1:0] {mls_idle, mls_active, mls_hold} mls_state_t;
   typedef enum logic {mls_mode_enable_low, mls_mode_add} mls_mode_t;
endpackage : mls_pkg

// ### rtl/mls_timer.sv
// Purpose: Loadable down counter advanced by a tick enable
// Assumes: Load has priority over counting
// Notes: done is a registered level, high while count is zero
`timescale 1ns/1ps
module mls_timer #(
   parameter int W = 12
) (
   input wire logic clk_sys,
   input wire logic rst,
   input wire logic tick,
   input wire logic load,
   input wire logic [W-1:0] load_value,
   output logic done
);
   logic [W-1:0] count;
   wire count_zero = (count == '0);
   wire [W-1:0] next_count = load ? load_value : ((tick && !count_zero) ? count - 1'b1 : count);

   always_ff @(posedge clk_sys) begin
      if (rst) begin
         count <= '0;
         done <= 1'b1;
      end else begin
         count <= next_count;
         done <= (next_count == '0);
      end
   end
endmodule : mls_timer

// ### testbench/mls_chk_sva.sv
// Purpose: Port checks for line signalling
// Assumes: Small tick counts, tick_div 0
// Notes: Bound into the top module
`timescale 1ns/1ps
module mls_chk (
   input wire logic clk_sys, rst, chip_reset_low, tx_mode_add, tx_active_in, tx_bit_in,
   input wire logic carrier_detect_in, receive_symbol_in, line_drive_gate, transmit_symbol_out,
   input wire logic transmit_activity_flag, transition_pulse_low, rx_valid, rx_bit, irq_out_low,
   input wire logic [7:0] irq_sources
);
   default clocking @(posedge clk_sys); endclocking
   default disable iff (rst || !chip_reset_low);
   sequence s_end;
      tx_active_in ##1 !tx_active_in;
   endsequence
   chk_gate_idle: assert property (!tx_active_in |=> line_drive_gate) else $error("gate busy");
   chk_enlow_bit: assert property (tx_active_in && !tx_mode_add |=> !line_drive_gate
      && transmit_symbol_out == $past(tx_bit_in)) else $error("enable-low bit");
   chk_add_bit: assert property (tx_active_in && tx_mode_add |=> line_drive_gate == $past(tx_bit_in)
      && transmit_symbol_out == $past(tx_bit_in)) else $error("add bit");
   chk_flag_on: assert property (tx_active_in |=> transmit_activity_flag) else $error("flag low");
   chk_flag_hold: assert property (s_end |=> transmit_activity_flag[*4]) else $error("hold short");
   chk_idle_lines: assert property (!tx_active_in[*8] |=> !transmit_activity_flag
      && transition_pulse_low) else $error("idle lines");
   chk_pulse_start: assert property ($rose(tx_active_in) |=> !transition_pulse_low[*4])
      else $error("start pulse");
   chk_pulse_mid: assert property (tx_active_in && $past(tx_active_in) && $changed(tx_bit_in)
      |=> !transition_pulse_low[*8]) else $error("mid pulse");
   chk_rx_follow: assert property (1'b1 |=> rx_valid == $past(carrier_detect_in)
      && rx_bit == ($past(carrier_detect_in) & $past(receive_symbol_in))) else $error("rx");
   chk_irq_level: assert property (1'b1 |=> irq_out_low == !(|$past(irq_sources))) else $error("irq");
endmodule : mls_chk
bind mls_line_signalling mls_chk u_chk (.*);

// ### testbench/mls_mau_model.sv
// Purpose: Line unit receive side
// Assumes: Stepped on the falling edge
// Notes: Symbol line toggles as noise without carrier
`timescale 1ns/1ps
module mls_mau_model (
   input wire logic clk_sys, sig_on, sig_bit,
   output logic carrier_detect_in, receive_symbol_in
);
   logic [1:0] seen = 2'h0;
   logic on_q = 1'b0;
   logic bit_q = 1'b0;
   wire logic valid = on_q && seen == 2'h3;
   initial carrier_detect_in = 1'b0;
   initial receive_symbol_in = 1'b0;
   // Bench stimulus also moves on the falling edge; sample it half a cycle later
   always @(posedge clk_sys) begin
      on_q <= sig_on;
      bit_q <= sig_bit;
   end
   always @(negedge clk_sys) begin
      seen <= on_q ? (valid ? seen : seen + 2'h1) : 2'h0;
      carrier_detect_in <= valid;
      receive_symbol_in <= valid ? bit_q : ~receive_symbol_in;
   end
endmodule : mls_mau_model

// ### testbench/tb.sv
// Purpose: Self-checking bench for line signalling
// Assumes: Small tick counts, tick_div 0 outside the divider test, which runs with tick_div 1
// Notes: Inputs change on the falling edge
`timescale 1ns/1ps
module tb;
   logic clk_sys = 1'b0, rst = 1'b1, chip_reset_low = 1'b1, tx_mode_add = 1'b0, tx_active_in = 1'b0;
   logic tx_bit_in = 1'b0, sig_on = 1'b0, sig_bit = 1'b0;
   logic [7:0] irq_sources = 8'h00, tick_div = 8'h00;
   logic carrier_detect_in, receive_symbol_in, line_drive_gate, transmit_symbol_out;
   logic transmit_activity_flag, transition_pulse_low, rx_valid, rx_bit, irq_out_low;
   int miscompares = 0, checked = 0, cycles = 0;
   mls_line_signalling #(.SHORT_TICKS(4), .LONG_TICKS(8), .HOLD_TICKS(4)) dut (.*);
   mls_mau_model mau (.*);
   initial forever #2 clk_sys = ~clk_sys;
   task automatic close_out;
      if (miscompares == 0 && checked > 0) begin
         $display("Simulation passed");
      end else begin
         $display("Simulation failed");
      end
      $finish;
   endtask : close_out
   task automatic chk(input string what, input logic exp, input logic got);
      checked++;
      if (got !== exp) begin
         miscompares++;
         $display("unexpected %s: expected %b seen %b", what, exp, got);
      end
   endtask : chk
   task automatic step(input int n);
      repeat (n) @(negedge clk_sys);
   endtask : step
   task automatic t_tx(input logic add);
      tx_mode_add = add;
      tx_active_in = 1'b1;
      tx_bit_in = 1'b1;
      step(1);
      chk("gate", add, line_drive_gate);
      chk("symbol", 1'b1, transmit_symbol_out);
      chk("pulse", 1'b0, transition_pulse_low);
      step(20);
      tx_bit_in = 1'b0;
      step(8);
      chk("gate", 1'b0, line_drive_gate);
      chk("symbol", 1'b0, transmit_symbol_out);
      chk("pulse", 1'b0, transition_pulse_low);
      step(20);
      chk("flag", 1'b1, transmit_activity_flag);
      tx_active_in = 1'b0;
      step(3);
      chk("flag", 1'b1, transmit_activity_flag);
      chk("gate", 1'b1, line_drive_gate);
      step(20);
      chk("flag", 1'b0, transmit_activity_flag);
      chk("pulse", 1'b1, transition_pulse_low);
   endtask : t_tx
   task automatic t_rx;
      step(6);
      chk("rx valid", 1'b0, rx_valid);
      sig_on = 1'b1;
      sig_bit = 1'b1;
      step(7);
      chk("rx valid", 1'b1, rx_valid);
      chk("rx bit", 1'b1, rx_bit);
      sig_bit = 1'b0;
      step(2);
      chk("rx bit", 1'b0, rx_bit);
      sig_on = 1'b0;
      step(3);
      chk("rx valid", 1'b0, rx_valid);
      chk("rx bit", 1'b0, rx_bit);
   endtask : t_rx
   task automatic t_div;
      int lows;
      lows = 0;
      tick_div = 8'h01;
      step(4);
      tx_active_in = 1'b1;
      step(1);
      while (transition_pulse_low === 1'b0 && lows < 40) begin
         lows++;
         step(1);
      end
      chk("div pulse", 1'b1, lows >= 8 && lows <= 10);
      tick_div = 8'h00;
      step(4);
      tx_active_in = 1'b0;
      step(20);
   endtask : t_div
   task automatic t_irq_reset;
      irq_sources = 8'h81;
      tx_active_in = 1'b1;
      step(2);
      chk("irq", 1'b0, irq_out_low);
      chip_reset_low = 1'b0;
      step(1);
      chk("flag", 1'b0, transmit_activity_flag);
      chk("rx valid", 1'b0, rx_valid);
      chk("irq", 1'b1, irq_out_low);
      chip_reset_low = 1'b1;
      tx_active_in = 1'b0;
      irq_sources = 8'h00;
      step(2);
      chk("irq", 1'b1, irq_out_low);
   endtask : t_irq_reset
   always @(posedge clk_sys) begin
      cycles++;
      if (cycles == 5000) begin
         miscompares++;
         close_out();
      end
   end
   initial begin
      step(5);
      rst = 1'b0;
      t_tx(1'b0);
      t_tx(1'b1);
      t_rx();
      t_div();
      t_irq_reset();
      close_out();
   end
endmodule : tb
